// file: src/atdi_pkg.sv
/*
  Package for the analog threshold digital input block: register map,
  field layouts, reset values and scheduler timing.
  Assumes percentages are held as unsigned hundredths of a percent.
*/
package atdi_pkg;
  localparam int ATDI_PCT_W = 16;
  localparam int ATDI_NUM_CH = 2;
  // hundredths of a percent
  localparam logic [15:0] ATDI_LEVEL_MAX = 16'h2710;
  localparam logic [15:0] ATDI_HYST_MAX = 16'h1388;
  localparam logic [15:0] ATDI_LEVEL_RST = 16'h1388;
  localparam logic [15:0] ATDI_HYST_RST = 16'h0000;
  // front-end span per range, in hundredths of a percent
  localparam logic [15:0] ATDI_SPAN_CURRENT = 16'h1130;
  localparam logic [15:0] ATDI_SPAN_VOLT = 16'h2710;
  // scheduler period
  localparam int ATDI_PERIOD_MS = 20;
  localparam int ATDI_CLK_MHZ = 100;
  localparam int ATDI_PERIOD_CYC = ATDI_PERIOD_MS * 1000 * ATDI_CLK_MHZ;
  // register byte offsets
  localparam logic [11:0] ATDI_CTRL_OFF = 12'h000;
  localparam logic [11:0] ATDI_LEVEL0_OFF = 12'h004;
  localparam logic [11:0] ATDI_HYST0_OFF = 12'h008;
  localparam logic [11:0] ATDI_LEVEL1_OFF = 12'h00c;
  localparam logic [11:0] ATDI_HYST1_OFF = 12'h010;
  localparam logic [11:0] ATDI_STATUS_OFF = 12'h014;
  localparam logic [11:0] ATDI_READING0_OFF = 12'h018;
  localparam logic [11:0] ATDI_READING1_OFF = 12'h01c;
  // ctrl fields: bit per channel
  localparam int ATDI_CTRL_INV_POS = 0;
  // status fields: outputs [1:0], history [3:2]
  localparam int ATDI_STAT_OUT_POS = 0;
  localparam int ATDI_STAT_HIST_POS = 2;
endpackage

// file: src/atdi_top.sv
/*
  Two-channel analog threshold digital input with hysteresis, APB slave.
  Assumes the front end delivers readings as hundredths of a percent of
  the 10 V voltage span in both ranges, synchronous to pclk.
*/
// The register addresses and the APB interface to the registers are this design's own decisions.
////////////////////////////////////////////////////////////////////////////
module atdi_top
  import atdi_pkg::*;
#(
  parameter int PERIOD_CYC = ATDI_PERIOD_CYC
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [15:0] reading0, // channel 0 percent reading
  input wire logic [15:0] reading1, // channel 1 percent reading
  output logic [1:0] digital_out, // per-channel boolean result
  output logic eval_tick // one-cycle pulse per evaluation
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] invert_reg, invert_next;
  logic [15:0] level_reg [2];
  logic [15:0] level_next [2];
  logic [15:0] hyst_reg [2];
  logic [15:0] hyst_next [2];
  logic [1:0] hist_reg, hist_next;
  logic [1:0] out_reg, out_next;
  logic [31:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [15:0] rd [2];
  logic setup, wr, mapped;

  // readings past the top of the span saturate at 100.00 percent for the compare; the reading registers return them unsaturated
  assign rd[0] = (reading0 > ATDI_SPAN_VOLT) ?
                 ATDI_SPAN_VOLT : reading0;
  assign rd[1] = (reading1 > ATDI_SPAN_VOLT) ?
                 ATDI_SPAN_VOLT : reading1;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready_reg;

  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input logic [15:0] mx);
    clamp = (v[31:16] != 16'h0000 || v[15:0] > mx) ? mx : v[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb slave: no wait states, ready in the first access cycle after setup
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      ATDI_CTRL_OFF, ATDI_LEVEL0_OFF, ATDI_HYST0_OFF, ATDI_LEVEL1_OFF,
      ATDI_HYST1_OFF, ATDI_STATUS_OFF, ATDI_READING0_OFF,
      ATDI_READING1_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = prdata_reg;
    if (setup && !pwrite) begin
      case (paddr)
        ATDI_CTRL_OFF: prdata_next = {30'h0, invert_reg};
        ATDI_LEVEL0_OFF: prdata_next = {16'h0, level_reg[0]};
        ATDI_HYST0_OFF: prdata_next = {16'h0, hyst_reg[0]};
        ATDI_LEVEL1_OFF: prdata_next = {16'h0, level_reg[1]};
        ATDI_HYST1_OFF: prdata_next = {16'h0, hyst_reg[1]};
        ATDI_STATUS_OFF: prdata_next = {28'h0, hist_reg, out_reg};
        ATDI_READING0_OFF: prdata_next = {16'h0, reading0};
        ATDI_READING1_OFF: prdata_next = {16'h0, reading1};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    invert_next = invert_reg;
    level_next = level_reg;
    hyst_next = hyst_reg;
    if (wr) begin
      case (paddr)
        ATDI_CTRL_OFF: invert_next = pwdata[ATDI_CTRL_INV_POS +: 2];
        ATDI_LEVEL0_OFF: level_next[0] = clamp(pwdata, ATDI_LEVEL_MAX);
        ATDI_HYST0_OFF: hyst_next[0] = clamp(pwdata, ATDI_HYST_MAX);
        ATDI_LEVEL1_OFF: level_next[1] = clamp(pwdata, ATDI_LEVEL_MAX);
        ATDI_HYST1_OFF: hyst_next[1] = clamp(pwdata, ATDI_HYST_MAX);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scheduler tick
  always_comb begin
    tick_next = 1'b0;
    if (cnt_reg >= 32'(PERIOD_CYC - 1)) begin
      cnt_next = 32'h0000_0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // threshold channels; 18-bit signed math so level+hyst cannot wrap and
  // level-hyst may drop below zero, where every reading counts as above
  logic signed [17:0] thr [2];
  logic signed [17:0] pct [2];
  always_comb begin
    hist_next = hist_reg;
    for (int i = 0; i < ATDI_NUM_CH; i++) begin
      pct[i] = $signed({2'b00, rd[i]});
      if (hist_reg[i])
        thr[i] = $signed({2'b00, level_reg[i]})
                 - $signed({2'b00, hyst_reg[i]});
      else
        thr[i] = $signed({2'b00, level_reg[i]})
                 + $signed({2'b00, hyst_reg[i]});
      if (tick_reg) begin
        if (pct[i] > thr[i])
          hist_next[i] = 1'b1;
        else if (pct[i] < thr[i])
          hist_next[i] = 1'b0;
        // equal reading holds
      end
    end
    out_next = hist_next ^ invert_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invert_reg <= 2'h0;
      level_reg <= '{ATDI_LEVEL_RST, ATDI_LEVEL_RST};
      hyst_reg <= '{ATDI_HYST_RST, ATDI_HYST_RST};
      hist_reg <= 2'h0;
      out_reg <= 2'h0;
      cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      invert_reg <= invert_next;
      level_reg <= level_next;
      hyst_reg <= hyst_next;
      hist_reg <= hist_next;
      out_reg <= out_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign digital_out = out_reg;
  assign eval_tick = tick_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  // band edges rebuilt apart from the channel logic
  logic signed [17:0] band_hi [2];
  logic signed [17:0] band_lo [2];
  assign band_hi[0] = 18'(level_reg[0]) + 18'(hyst_reg[0]);
  assign band_hi[1] = 18'(level_reg[1]) + 18'(hyst_reg[1]);
  assign band_lo[0] = 18'(level_reg[0]) - 18'(hyst_reg[0]);
  assign band_lo[1] = 18'(level_reg[1]) - 18'(hyst_reg[1]);

  // bus side
  ready_after_setup_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup |=> pready_reg)
    else $error("no ready after setup");
  ready_pulse_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready_reg |=> !pready_reg)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pslverr_reg |-> pready_reg)
    else $error("error without ready");
  err_unmapped_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup && !mapped |=> pslverr_reg)
    else $error("unmapped access not flagged");
  err_mapped_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup && mapped |=> !pslverr_reg)
    else $error("mapped access flagged");
  status_read_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup && !pwrite && paddr == ATDI_STATUS_OFF |=>
      prdata_reg == {28'h0, $past(hist_reg), $past(out_reg)})
    else $error("status read wrong");
  prdata_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(setup && !pwrite) |=> $stable(prdata_reg))
    else $error("read data moved without a read");

  // settings
  ctrl_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && paddr == ATDI_CTRL_OFF |=> invert_reg == $past(pwdata[1:0]))
    else $error("invert write lost");
  level_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && paddr == ATDI_LEVEL0_OFF && pwdata <= 32'(ATDI_LEVEL_MAX) |=>
      level_reg[0] == $past(pwdata[15:0]))
    else $error("level write lost");
  level_clamp_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && paddr == ATDI_LEVEL1_OFF && pwdata > 32'(ATDI_LEVEL_MAX) |=>
      level_reg[1] == ATDI_LEVEL_MAX)
    else $error("level not clamped");
  hyst_write_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && paddr == ATDI_HYST1_OFF && pwdata <= 32'(ATDI_HYST_MAX) |=>
      hyst_reg[1] == $past(pwdata[15:0]))
    else $error("hysteresis write lost");
  hyst_clamp_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr && paddr == ATDI_HYST0_OFF && pwdata > 32'(ATDI_HYST_MAX) |=>
      hyst_reg[0] == ATDI_HYST_MAX)
    else $error("hysteresis not clamped");
  cfg_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !wr |=> $stable(level_reg[0]) && $stable(level_reg[1]) &&
      $stable(hyst_reg[0]) && $stable(hyst_reg[1]) && $stable(invert_reg))
    else $error("setting changed without a write");
  level_range_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    level_reg[0] <= ATDI_LEVEL_MAX && level_reg[1] <= ATDI_LEVEL_MAX)
    else $error("level out of range");
  hyst_range_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    hyst_reg[0] <= ATDI_HYST_MAX && hyst_reg[1] <= ATDI_HYST_MAX)
    else $error("hysteresis out of range");

  // scheduler
  tick_space_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg |=> !tick_reg)
    else $error("ticks back to back");
  tick_wrap_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg |-> cnt_reg == 32'h0000_0000)
    else $error("tick without counter wrap");
  cnt_bound_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    cnt_reg <= 32'(PERIOD_CYC - 1))
    else $error("period counter overran");
  hist_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !tick_reg |=> hist_reg == $past(hist_reg))
    else $error("history changed without a tick");

  // channels
  span_cap_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    pct[0] <= $signed(18'(ATDI_SPAN_VOLT)) &&
      pct[1] <= $signed(18'(ATDI_SPAN_VOLT)))
    else $error("reading above full span");
  rise_above_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && !hist_reg[0] && pct[0] > band_hi[0] |=> hist_reg[0])
    else $error("ch0 did not rise above upper threshold");
  rise_above1_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && !hist_reg[1] && pct[1] > band_hi[1] |=> hist_reg[1])
    else $error("ch1 did not rise above upper threshold");
  fall_below_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && hist_reg[0] && pct[0] < band_lo[0] |=> !hist_reg[0])
    else $error("ch0 did not fall below lower threshold");
  fall_below1_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && hist_reg[1] && pct[1] < band_lo[1] |=> !hist_reg[1])
    else $error("ch1 did not fall below lower threshold");
  upper_band_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && !hist_reg[1] && pct[1] <= band_hi[1] |=> !hist_reg[1])
    else $error("ch1 rose inside the band");
  upper_band0_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && !hist_reg[0] && pct[0] <= band_hi[0] |=> !hist_reg[0])
    else $error("ch0 rose inside the band");
  lower_band_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && hist_reg[1] && pct[1] >= band_lo[1] |=> hist_reg[1])
    else $error("ch1 fell inside the band");
  lower_band0_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && hist_reg[0] && pct[0] >= band_lo[0] |=> hist_reg[0])
    else $error("ch0 fell inside the band");
  equal_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && pct[0] == thr[0] |=> hist_reg[0] == $past(hist_reg[0]))
    else $error("ch0 equal reading changed history");
  equal_hold1_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_reg && pct[1] == thr[1] |=> hist_reg[1] == $past(hist_reg[1]))
    else $error("ch1 equal reading changed history");

  // output stage
  invert_out_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    ##1 out_reg == (hist_reg ^ $past(invert_reg)))
    else $error("output not history xor invert");
  out_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !tick_reg && $stable(invert_reg) |=> $stable(out_reg))
    else $error("output moved with nothing to move it");

endmodule

// file: verif/atdi_front_end.sv
/*
  Front-end model: turns a terminal level into hundredths of a percent.
  Assumes voltage levels in mV over a 10 V span, current levels in uA.
*/
module atdi_front_end (
  input wire logic pclk, // sampling clock
  input wire logic current_mode, // high: 0 to 20 mA range
  input wire logic [15:0] level_in, // mV or uA at the terminal
  output logic [15:0] reading // percent reading, hundredths
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] scaled;
  always_comb begin
    if (current_mode) scaled = 32'(level_in) * 32'h1130 / 32'h4e20;
    else scaled = 32'(level_in);
  end
  always_ff @(posedge pclk) reading <= scaled[15:0];
endmodule

// file: verif/analog_threshold_digital_input_tb.sv
/*
  Self-checking bench for atdi_top over APB with two front-end models.
  Assumes a short evaluation period set through PERIOD_CYC.
*/
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module analog_threshold_digital_input_tb;
  import atdi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, eval_tick, er, cur1 = 0;
  logic [1:0] digital_out;
  logic [15:0] lv0 = 0, lv1 = 0, reading0, reading1;
  localparam int SIM_PERIOD = 20;
  int err_count = 0, check_count = 0;
  always #5 pclk = ~pclk;
  atdi_front_end fe0 (.pclk(pclk), .current_mode(1'b0), .level_in(lv0),
    .reading(reading0));
  atdi_front_end fe1 (.pclk(pclk), .current_mode(cur1), .level_in(lv1),
    .reading(reading1));
  atdi_top #(.PERIOD_CYC(SIM_PERIOD)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reading0(reading0), .reading1(reading1), .digital_out(digital_out),
    .eval_tick(eval_tick));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin err_count++; report_and_stop(); end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // waits for a tick and the update edge behind it
  task automatic eval_wait;
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge pclk);
      if (eval_tick === 1'b1) break;
    end
    if (n == 60) begin err_count++; report_and_stop(); end
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    apb(0, ATDI_CTRL_OFF, 0); `CHK("ctrl", 32'h0, rd)
    apb(0, ATDI_LEVEL0_OFF, 0); `CHK("level0", 32'h1388, rd)
    apb(0, ATDI_HYST0_OFF, 0); `CHK("hyst0", 32'h0, rd)
    apb(0, ATDI_STATUS_OFF, 0); `CHK("status", 32'h0, rd)
  endtask
  task automatic tick_period;
    int c;
    eval_wait();
    for (c = 1; c < 60 && eval_tick !== 1'b1; c++) @(posedge pclk);
    `CHK("period", SIM_PERIOD, c)
  endtask
  task automatic bad_access;
    apb(1, 12'h020, 32'h1); `CHK("werr", 1'b1, er)
    apb(0, 12'h020, 0); `CHK("rerr", 1'b1, er)
    `CHK("rdata", 32'h0, rd)
  endtask
  task automatic clamp;
    apb(1, ATDI_LEVEL1_OFF, 32'hffff);
    apb(0, ATDI_LEVEL1_OFF, 0); `CHK("lvmax", 32'h2710, rd)
    apb(1, ATDI_HYST1_OFF, 32'hffff);
    apb(0, ATDI_HYST1_OFF, 0); `CHK("hymax", 32'h1388, rd)
  endtask
  task automatic hysteresis;
    logic [15:0] v0 [6] = '{16'd5400, 16'd5600, 16'd4600, 16'd4500,
                            16'd4400, 16'd5600};
    logic [15:0] v1 [6] = '{16'd20000, 16'd0, 16'd10000, 16'd20000,
                            16'd10000, 16'd0};
    logic [1:0] ex [6] = '{2'b10, 2'b01, 2'b01, 2'b11, 2'b10, 2'b01};
    // mid-span levels: 50% volts, 22% current
    apb(1, ATDI_HYST0_OFF, 32'h01f4);
    apb(1, ATDI_LEVEL1_OFF, 32'h0898);
    apb(1, ATDI_HYST1_OFF, 32'h0);
    cur1 <= 1;
    for (int i = 0; i < 6; i++) begin
      lv0 <= v0[i];
      lv1 <= v1[i];
      eval_wait();
      eval_wait();
      `CHK("dout", ex[i], digital_out)
      if (i == 0) begin
        apb(0, ATDI_READING1_OFF, 0); `CHK("rd1", 32'h1130, rd)
      end
    end
  endtask
  task automatic invert;
    apb(1, ATDI_CTRL_OFF, 32'h3);
    eval_wait();
    `CHK("inv", 2'b10, digital_out)
    apb(0, ATDI_STATUS_OFF, 0); `CHK("stat", 32'h6, rd)
    apb(0, ATDI_READING0_OFF, 0); `CHK("rd0", 32'h15e0, rd)
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    `CHK("dout0", 2'b00, digital_out)
    reset_values();
    tick_period();
    bad_access();
    clamp();
    hysteresis();
    invert();
    report_and_stop();
  end
endmodule
